// ==== rss_pkg.sv ====
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package rss_pkg;

  // --------------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;        // ref_clk period
  localparam int DETECT_TO_RUN_NS = 2000;    // detector recovery to run
  // roughly-stated delay, so round down, never below one cycle
  localparam int DETECT_TO_RUN_CYCLES =
    (DETECT_TO_RUN_NS / CLK_PERIOD_NS) < 1 ? 1 : (DETECT_TO_RUN_NS / CLK_PERIOD_NS);
  localparam int INIT_CYCLES = 8;            // cpu and register init phase
  localparam int SOFT_HOLD_CYCLES = 4;       // reset pulse for internal causes
  localparam int CNT_W = 16;                 // sequencer counter width

  // --------------------------------------------------------------------------
  // register map, byte addresses
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;   // reset control
  localparam logic [ADDR_W-1:0] VDET_OFFSET = 8'h04;   // voltage detect control two
  localparam logic [ADDR_W-1:0] STAT_OFFSET = 8'h08;   // status, read only
  localparam logic [ADDR_W-1:0] KEEP_OFFSET = 8'h0c;   // retained scratch word

  // control register fields
  localparam int CTRL_SW_REQ_BIT = 0;        // software_reset_request
  localparam int CTRL_WDT_SEL_BIT = 1;       // watchdog_reset_select
  localparam int CTRL_OSC_EN_BIT = 2;        // osc_stop_detect_enable
  localparam int CTRL_OSC_ACT_BIT = 3;       // osc_stop_action_select
  localparam int VDET_EN_BIT = 0;            // reset_level_detect_enable
  // status fields
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_PHASE_LSB = 4;
  localparam int STAT_PIN_BIT = 8;

  // values after reset
  localparam logic CTRL_WDT_SEL_RESET = 1'b0;
  localparam logic CTRL_OSC_EN_RESET = 1'b0;
  localparam logic CTRL_OSC_ACT_RESET = 1'b0;
  localparam logic VDET_EN_RESET = 1'b0;
  localparam logic [31:0] KEEP_RESET = 32'h0000_0000;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSS_RUN = 2'h0,
    RSS_HOLD = 2'h1,
    RSS_INIT = 2'h3,
    RSS_FETCH = 2'h2
  } rss_phase_t;

  typedef enum logic [2:0] {
    RSS_CAUSE_POWER = 3'h0,
    RSS_CAUSE_PIN = 3'h1,
    RSS_CAUSE_BROWNOUT = 3'h2,
    RSS_CAUSE_SOFT = 3'h3,
    RSS_CAUSE_WDT = 3'h4,
    RSS_CAUSE_OSC = 3'h5
  } rss_cause_t;

  typedef enum logic [2:0] {
    RSS_SEL_CTRL, RSS_SEL_VDET, RSS_SEL_STAT, RSS_SEL_KEEP, RSS_SEL_NONE
  } rss_sel_t;

  // master to slave
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } rss_axi_in_t;

  // slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rss_axi_out_t;

  // reset outputs to the rest of the device
  typedef struct packed {
    logic pins_reset;        // pins in reset state
    logic cpu_reset;         // cpu held
    logic sfr_full_reset;    // all registers to reset values
    logic sfr_part_reset;    // registers except retained ones
    logic osc_restart;       // on-chip oscillator reinitialised
    logic clk_sel_onchip;    // cpu clock forced to on-chip oscillator
    logic fetch_vector;      // one-cycle pulse: fetch reset vector
  } rss_rst_out_t;

  // two-stage synchroniser state
  typedef struct packed {
    logic meta;
    logic out;
  } rss_sync_t;

endpackage

// ----------------------------------------------------------------------------
// reset synchroniser: asserts at once, releases after two edges
// ----------------------------------------------------------------------------
module rss_reset_sync
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  output logic sync_n
);

  rss_sync_t q;       // registered state
  rss_sync_t next_q;  // next state

  // first stage feeds only the second stage
  always_comb begin
    next_q.meta = 1'b1;
    next_q.out = q.meta;
  end

  // constant on async assertion only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_n = q.out;

endmodule

// ==== rss_reset_source_sequencer.sv ====
// ----------------------------------------------------------------------------
// reset source sequencer top
// ----------------------------------------------------------------------------
module rss_reset_source_sequencer
  import rss_pkg::*;
#(
  parameter int DETECT_CYCLES = DETECT_TO_RUN_CYCLES
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic supply_below_threshold,
  input wire logic stop_mode,
  input wire logic wdt_underflow,
  input wire logic osc_stop_detected,
  input wire rss_axi_in_t axi_in,
  output rss_axi_out_t axi_out,
  output rss_rst_out_t rst_out
);

  // --------------------------------------------------------------------------
  // constants at counter width
  // --------------------------------------------------------------------------
  localparam logic [CNT_W-1:0] DETECT_LAST = CNT_W'(DETECT_CYCLES - 1);
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] SOFT_LAST = CNT_W'(SOFT_HOLD_CYCLES - 1);

  // --------------------------------------------------------------------------
  // module state, one packed struct
  // --------------------------------------------------------------------------
  typedef struct packed {
    rss_phase_t phase;          // sequencer phase
    rss_cause_t cause;          // cause being served
    rss_cause_t last_cause;     // cause of most recent reset
    logic [CNT_W-1:0] cnt;      // phase counter
    logic wdt_sel;              // watchdog_reset_select
    logic osc_en;               // osc_stop_detect_enable
    logic osc_act;              // osc_stop_action_select
    logic vdet_en;              // reset_level_detect_enable
    logic [31:0] keep;          // retained word
    logic aw_got;               // write address held
    logic [ADDR_W-1:0] awaddr;
    logic w_got;                // write data held
    logic [31:0] wdata;
    logic [3:0] wstrb;
    rss_axi_out_t axo;          // bus outputs
    rss_rst_out_t ro;           // reset outputs
  } rss_top_t;

  rss_top_t q;       // registered state
  rss_top_t next_q;  // next state
  logic rst_n;       // synchronised block reset
  logic pin_n;       // synchronised reset pin

  // --------------------------------------------------------------------------
  // address decode, shared by read and write paths
  // --------------------------------------------------------------------------
  function automatic rss_sel_t rss_decode(input logic [ADDR_W-1:0] addr);
    unique case (addr)
      CTRL_OFFSET: rss_decode = RSS_SEL_CTRL;
      VDET_OFFSET: rss_decode = RSS_SEL_VDET;
      STAT_OFFSET: rss_decode = RSS_SEL_STAT;
      KEEP_OFFSET: rss_decode = RSS_SEL_KEEP;
      default: rss_decode = RSS_SEL_NONE;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------------
  // block reset released through two flops
  rss_reset_sync u_rst_sync (
    .clk(ref_clk),
    .arst_n(resetn),
    .sync_n(rst_n)
  );

  // pin low drops the copy at once, release waits two edges
  rss_reset_sync u_pin_sync (
    .clk(ref_clk),
    .arst_n(reset_pin_n & resetn),
    .sync_n(pin_n)
  );

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    logic sw_hit;          // software reset requested this cycle
    logic brown;           // brown-out reset condition
    logic wdt_hit;         // watchdog reset condition
    logic osc_hit;         // oscillator-stop reset condition
    logic soft_any;        // any internal cause
    logic hard_entry;      // entering reset for pin or brown-out
    logic soft_entry;      // entering reset for an internal cause
    rss_cause_t new_cause; // cause picked this cycle
    rss_sel_t wsel;        // write target
    rss_sel_t rsel;        // read target
    sw_hit = 1'b0;
    brown = 1'b0;
    wdt_hit = 1'b0;
    osc_hit = 1'b0;
    soft_any = 1'b0;
    hard_entry = 1'b0;
    soft_entry = 1'b0;
    new_cause = RSS_CAUSE_PIN;
    wsel = rss_decode(q.awaddr);
    rsel = rss_decode(axi_in.araddr);
    next_q = q;
    next_q.ro.fetch_vector = 1'b0;

    // ---------------- write channel ----------------
    // address and data are taken in either order
    if (axi_in.awvalid && q.axo.awready) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = axi_in.awaddr;
    end
    if (axi_in.wvalid && q.axo.wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = axi_in.wdata;
      next_q.wstrb = axi_in.wstrb;
    end
    // retire a response
    if (q.axo.bvalid && axi_in.bready) begin
      next_q.axo.bvalid = 1'b0;
    end
    // both halves held and no response pending: perform the write
    if (q.aw_got && q.w_got && !q.axo.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.axo.bvalid = 1'b1;
      next_q.axo.bresp = RESP_OKAY;
      unique case (wsel)
        RSS_SEL_CTRL: begin
          if (q.wstrb[0]) begin
            // request bit self-clears; a written one fires a reset
            sw_hit = q.wdata[CTRL_SW_REQ_BIT];
            next_q.wdt_sel = q.wdata[CTRL_WDT_SEL_BIT];
            next_q.osc_en = q.wdata[CTRL_OSC_EN_BIT];
            next_q.osc_act = q.wdata[CTRL_OSC_ACT_BIT];
          end
        end
        RSS_SEL_VDET: begin
          if (q.wstrb[0]) begin
            next_q.vdet_en = q.wdata[VDET_EN_BIT];
          end
        end
        RSS_SEL_KEEP: begin
          // byte lanes honoured
          for (int i = 0; i < 4; i++) begin
            if (q.wstrb[i]) begin
              next_q.keep[i*8 +: 8] = q.wdata[i*8 +: 8];
            end
          end
        end
        RSS_SEL_STAT: begin
          // read-only, write ignored
        end
        default: begin
          next_q.axo.bresp = RESP_SLVERR;
        end
      endcase
    end

    // ---------------- read channel ----------------
    if (q.axo.rvalid && axi_in.rready) begin
      next_q.axo.rvalid = 1'b0;
    end
    if (axi_in.arvalid && q.axo.arready) begin
      next_q.axo.rvalid = 1'b1;
      next_q.axo.rresp = RESP_OKAY;
      next_q.axo.rdata = '0;
      unique case (rsel)
        RSS_SEL_CTRL: begin
          next_q.axo.rdata[CTRL_WDT_SEL_BIT] = q.wdt_sel;
          next_q.axo.rdata[CTRL_OSC_EN_BIT] = q.osc_en;
          next_q.axo.rdata[CTRL_OSC_ACT_BIT] = q.osc_act;
        end
        RSS_SEL_VDET: begin
          next_q.axo.rdata[VDET_EN_BIT] = q.vdet_en;
        end
        RSS_SEL_STAT: begin
          next_q.axo.rdata[STAT_CAUSE_LSB +: 3] = q.last_cause;
          next_q.axo.rdata[STAT_PHASE_LSB +: 2] = q.phase;
          next_q.axo.rdata[STAT_PIN_BIT] = pin_n;
        end
        RSS_SEL_KEEP: begin
          next_q.axo.rdata = q.keep;
        end
        default: begin
          next_q.axo.rresp = RESP_SLVERR;
        end
      endcase
    end

    // ---------------- reset causes ----------------
    // brown-out only when enabled and not in stop mode
    brown = supply_below_threshold && q.vdet_en && !stop_mode;
    // watchdog underflow only when selected
    wdt_hit = wdt_underflow && q.wdt_sel;
    // oscillator stop only when enabled with reset action
    osc_hit = osc_stop_detected && q.osc_en && !q.osc_act;
    soft_any = sw_hit || wdt_hit || osc_hit;
    // fixed priority: pin, brown-out, watchdog, oscillator, software
    if (!pin_n) begin
      new_cause = RSS_CAUSE_PIN;
    end else if (brown) begin
      new_cause = RSS_CAUSE_BROWNOUT;
    end else if (wdt_hit) begin
      new_cause = RSS_CAUSE_WDT;
    end else if (osc_hit) begin
      new_cause = RSS_CAUSE_OSC;
    end else begin
      new_cause = RSS_CAUSE_SOFT;
    end

    // ---------------- sequencer ----------------
    unique case (q.phase)
      RSS_RUN: begin
        if (!pin_n || brown) begin
          hard_entry = 1'b1;
        end else if (soft_any) begin
          soft_entry = 1'b1;
        end
      end
      RSS_HOLD: begin
        if (!pin_n && q.cause != RSS_CAUSE_PIN) begin
          hard_entry = 1'b1;
        end else begin
          next_q.cnt = q.cnt + CNT_W'(1);
          unique case (q.cause)
            // release waits for the synchronised pin to go high
            RSS_CAUSE_PIN: begin
              if (pin_n) begin
                next_q.phase = RSS_INIT;
                next_q.cnt = '0;
              end
            end
            // hold until supply is back at the threshold
            RSS_CAUSE_BROWNOUT: begin
              if (!supply_below_threshold) begin
                next_q.phase = RSS_INIT;
                next_q.cnt = '0;
              end
            end
            default: begin
              if (q.cnt == SOFT_LAST) begin
                next_q.phase = RSS_INIT;
                next_q.cnt = '0;
              end
            end
          endcase
        end
      end
      RSS_INIT: begin
        if (!pin_n || (q.cause == RSS_CAUSE_BROWNOUT && supply_below_threshold)) begin
          hard_entry = 1'b1;
          // a renewed dip keeps the brown-out cause, the enable being cleared by now
          new_cause = pin_n ? RSS_CAUSE_BROWNOUT : RSS_CAUSE_PIN;
        end else begin
          next_q.cnt = q.cnt + CNT_W'(1);
          // brown-out recovery takes the detect-to-run delay
          if (q.cnt == ((q.cause == RSS_CAUSE_BROWNOUT) ? DETECT_LAST : INIT_LAST)) begin
            next_q.phase = RSS_FETCH;
            next_q.cnt = '0;
          end
        end
      end
      RSS_FETCH: begin
        // one cycle to fetch the vector, then run
        next_q.phase = RSS_RUN;
        if (!pin_n) begin
          hard_entry = 1'b1;
        end
      end
      default: begin
        hard_entry = 1'b1;
      end
    endcase

    // ---------------- entering reset ----------------
    if (hard_entry || soft_entry) begin
      next_q.phase = RSS_HOLD;
      next_q.cnt = '0;
      next_q.cause = new_cause;
      next_q.last_cause = new_cause;
      // control bits return to reset values on every cause
      next_q.wdt_sel = CTRL_WDT_SEL_RESET;
      next_q.osc_en = CTRL_OSC_EN_RESET;
      next_q.osc_act = CTRL_OSC_ACT_RESET;
    end
    if (hard_entry) begin
      // only pin and brown-out clear the retained set
      next_q.vdet_en = VDET_EN_RESET;
      next_q.keep = KEEP_RESET;
    end

    // ---------------- bus handshake readiness ----------------
    next_q.axo.awready = !next_q.aw_got && !next_q.axo.bvalid;
    next_q.axo.wready = !next_q.w_got && !next_q.axo.bvalid;
    next_q.axo.arready = !next_q.axo.rvalid;

    // ---------------- reset outputs, from the next phase ----------------
    // pins stay in reset state until the vector fetch
    next_q.ro.pins_reset = next_q.phase != RSS_RUN && next_q.phase != RSS_FETCH;
    // cpu held through hold and init
    next_q.ro.cpu_reset = next_q.phase == RSS_HOLD || next_q.phase == RSS_INIT;
    // hard causes initialise everything; others spare retained registers
    next_q.ro.sfr_full_reset = next_q.ro.cpu_reset &&
      (next_q.cause == RSS_CAUSE_PIN || next_q.cause == RSS_CAUSE_BROWNOUT);
    next_q.ro.sfr_part_reset = next_q.ro.cpu_reset && !next_q.ro.sfr_full_reset;
    // oscillator restarted while pin or brown-out reset is held
    next_q.ro.osc_restart = next_q.phase == RSS_HOLD && next_q.ro.sfr_full_reset;
    // every cause leaves the on-chip oscillator as cpu clock
    next_q.ro.clk_sel_onchip = next_q.ro.cpu_reset || next_q.phase == RSS_FETCH;
    next_q.ro.fetch_vector = next_q.phase == RSS_FETCH && q.phase != RSS_FETCH;
    // no ram clear exists here: ram is outside every reset
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // power-up state is a held reset, so outputs start asserted
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.phase <= RSS_HOLD;
      q.cause <= RSS_CAUSE_PIN;
      q.last_cause <= RSS_CAUSE_POWER;
      q.wdt_sel <= CTRL_WDT_SEL_RESET;
      q.osc_en <= CTRL_OSC_EN_RESET;
      q.osc_act <= CTRL_OSC_ACT_RESET;
      q.vdet_en <= VDET_EN_RESET;
      q.keep <= KEEP_RESET;
      q.ro.pins_reset <= 1'b1;
      q.ro.cpu_reset <= 1'b1;
      q.ro.sfr_full_reset <= 1'b1;
      q.ro.osc_restart <= 1'b1;
      q.ro.clk_sel_onchip <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // --------------------------------------------------------------------------
  // outputs straight from the state register
  // --------------------------------------------------------------------------
  assign axi_out = q.axo;
  assign rst_out = q.ro;

endmodule

// ==== rss_reset_circuit_model.sv ====
// ----------------------------------------------------------------------------
// external reset circuit and supply supervisor
// ----------------------------------------------------------------------------
module rss_reset_circuit_model
  import rss_pkg::*;
#(
  parameter int OSC_START_CYCLES = 3,  // oscillator_start_wait, in clocks
  parameter int REG_SETTLE_CYCLES = 2  // regulator_settle_wait, in clocks
)(
  input wire logic ref_clk,
  output logic reset_pin_n,
  output logic supply_below_threshold
);
  // power-on: pin low through settle plus oscillator start
  initial begin
    reset_pin_n = 1'b0;
    supply_below_threshold = 1'b0;
    repeat (REG_SETTLE_CYCLES + OSC_START_CYCLES) @(posedge ref_clk);
    reset_pin_n <= 1'b1;
  end

  // pin pulse, never shorter than the oscillator start wait
  task automatic pin_reset(input int hold);
    reset_pin_n <= 1'b0;
    repeat (hold < OSC_START_CYCLES ? OSC_START_CYCLES : hold) @(posedge ref_clk);
    reset_pin_n <= 1'b1;
  endtask

  // supply dip below the reset threshold
  task automatic brownout(input int hold);
    supply_below_threshold <= 1'b1;
    repeat (hold) @(posedge ref_clk);
    supply_below_threshold <= 1'b0;
    // let one edge pass so a following dip never lands in the same step
    @(posedge ref_clk);
  endtask
endmodule

// ==== rss_sequencer_asserts.sv ====
// ----------------------------------------------------------------------------
// reset sequencer checker
// ----------------------------------------------------------------------------
module rss_sequencer_asserts
  import rss_pkg::*;
#(
  parameter int DETECT_CYCLES = DETECT_TO_RUN_CYCLES
)(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic supply_below_threshold,
  input wire logic stop_mode,
  input wire logic wdt_underflow,
  input wire logic osc_stop_detected,
  input wire rss_axi_in_t axi_in,
  input wire rss_axi_out_t axi_out,
  input wire rss_rst_out_t rst_out
);
  localparam int BO_LO = DETECT_CYCLES;     // earliest fetch after recovery
  localparam int BO_HI = DETECT_CYCLES + 4; // slack for sync and hold exit
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // cpu held with pins and clock forced
  sequence held;
    rst_out.cpu_reset && rst_out.pins_reset && rst_out.clk_sel_onchip;
  endsequence
  // internal cause: 4 hold plus 8 init, then fetch
  sequence internal_walk;
    held[*8] ##1 held[*4] ##1 (rst_out.fetch_vector && !rst_out.cpu_reset);
  endsequence
  // pin released and kept high
  sequence pin_released;
    $rose(reset_pin_n) ##1 reset_pin_n[*8];
  endsequence

  AST_PIN_HOLD: assert property ((!reset_pin_n)[*2] |-> held ##0
    (rst_out.osc_restart && rst_out.sfr_full_reset)) else $error("pin low not held");
  AST_PIN_SYNC: assert property ($rose(reset_pin_n) |=>
    rst_out.osc_restart[*2] ##1 !rst_out.osc_restart) else $error("pin release not registered");
  AST_PIN_RELEASE: assert property (pin_released |-> ##[1:5] rst_out.fetch_vector)
    else $error("no fetch after pin release");
  AST_FETCH_ONE: assert property (rst_out.fetch_vector && reset_pin_n |=>
    !rst_out.fetch_vector && !rst_out.clk_sel_onchip) else $error("fetch not single");
  AST_FETCH_AFTER: assert property ($fell(rst_out.cpu_reset) |-> rst_out.fetch_vector)
    else $error("cpu released without fetch");
  AST_INTERNAL_WALK: assert property ($rose(rst_out.sfr_part_reset) |-> internal_walk)
    else $error("internal reset walk wrong");
  AST_FULL_ONLY: assert property (rst_out.osc_restart |->
    rst_out.sfr_full_reset && !rst_out.sfr_part_reset) else $error("restart on partial reset");
  AST_SFR_SPLIT: assert property (((rst_out.sfr_full_reset | rst_out.sfr_part_reset)
    == rst_out.cpu_reset) && !(rst_out.sfr_full_reset && rst_out.sfr_part_reset))
    else $error("register reset split wrong");
  AST_STOP_IGNORE: assert property (stop_mode && reset_pin_n && !rst_out.cpu_reset
    && !wdt_underflow && !osc_stop_detected && axi_out.awready && !axi_in.wvalid
    |=> !rst_out.cpu_reset) else $error("reset in stop mode");
  AST_BROWNOUT_RUN: assert property ($fell(supply_below_threshold) && rst_out.osc_restart
    |-> ##[BO_LO:BO_HI] rst_out.fetch_vector) else $error("brown-out recovery timing");
endmodule

bind rss_reset_source_sequencer rss_sequencer_asserts #(.DETECT_CYCLES(DETECT_CYCLES)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
  .supply_below_threshold(supply_below_threshold), .stop_mode(stop_mode),
  .wdt_underflow(wdt_underflow), .osc_stop_detected(osc_stop_detected),
  .axi_in(axi_in), .axi_out(axi_out), .rst_out(rst_out));

// ==== rss_reset_source_sequencer_tb_top.sv ====
// ----------------------------------------------------------------------------
// reset sequencer testbench
// ----------------------------------------------------------------------------
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED at %0t: got %h want %h", $time, (a), (b)); end end
module rss_reset_source_sequencer_tb_top
  import rss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, resetn = 1'b0, stop_mode = 1'b0; // bench drives
  logic wdt_underflow = 1'b0, osc_stop_detected = 1'b0;
  logic reset_pin_n, supply_below_threshold; // from the supply model
  rss_axi_in_t axi_in = '0;
  rss_axi_out_t axi_out;
  rss_rst_out_t rst_out;
  int num_errors = 0, checked = 0, cycles = 0, n;
  logic seen_part = 1'b0, seen_full = 1'b0; // reset kind seen since last clear
  logic [31:0] keep = 32'hc3a5_5a3c;

  always #50 ref_clk = ~ref_clk;

  rss_reset_circuit_model u_supply (.ref_clk(ref_clk), .reset_pin_n(reset_pin_n),
    .supply_below_threshold(supply_below_threshold));
  // short brown-out recovery keeps the run brief
  rss_reset_source_sequencer #(.DETECT_CYCLES(3)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .reset_pin_n(reset_pin_n), .supply_below_threshold(supply_below_threshold),
    .stop_mode(stop_mode), .wdt_underflow(wdt_underflow),
    .osc_stop_detected(osc_stop_detected), .axi_in(axi_in), .axi_out(axi_out),
    .rst_out(rst_out));

  // reset kind monitor and hang guard
  always @(posedge ref_clk) begin
    if (rst_out.sfr_part_reset === 1'b1) seen_part <= 1'b1;
    if (rst_out.sfr_full_reset === 1'b1) seen_full <= 1'b1;
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_in.awvalid <= 1'b1; axi_in.awaddr <= a; axi_in.wvalid <= 1'b1;
    axi_in.wdata <= d; axi_in.wstrb <= 4'hf; axi_in.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axi_in.awvalid && axi_out.awready) axi_in.awvalid <= 1'b0;
      if (axi_in.wvalid && axi_out.wready) axi_in.wvalid <= 1'b0;
    end while (axi_out.bvalid !== 1'b1);
    axi_in.bready <= 1'b0;
    `CHK(axi_out.bresp, er)
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    axi_in.arvalid <= 1'b1; axi_in.araddr <= a; axi_in.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (axi_in.arvalid && axi_out.arready) axi_in.arvalid <= 1'b0;
    end while (axi_out.rvalid !== 1'b1);
    axi_in.rready <= 1'b0;
    `CHK(axi_out.rdata, ed)
    `CHK(axi_out.rresp, er)
    @(posedge ref_clk);
  endtask

  // cycles until the vector fetch pulse
  task automatic wait_fetch(output int k);
    k = 0;
    do begin @(posedge ref_clk); k++; end while (rst_out.fetch_vector !== 1'b1 && k < 200);
    `CHK(rst_out.fetch_vector, 1'b1)
    @(posedge ref_clk);
  endtask

  // one-cycle pulse on a watchdog or oscillator-stop input
  task automatic pulse(input int which);
    if (which == 0) wdt_underflow <= 1'b1; else osc_stop_detected <= 1'b1;
    @(posedge ref_clk);
    wdt_underflow <= 1'b0; osc_stop_detected <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_fetch(n);
    rd(STAT_OFFSET, 32'h100, RESP_OKAY);
    rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
    rd(VDET_OFFSET, 32'h0, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h1, RESP_SLVERR);
    wr(STAT_OFFSET, 32'h7, RESP_OKAY);
    rd(STAT_OFFSET, 32'h100, RESP_OKAY);
    $display("test registers done");
    wr(KEEP_OFFSET, keep, RESP_OKAY);
    wr(VDET_OFFSET, 32'h1, RESP_OKAY);
    seen_full = 1'b0;
    wr(CTRL_OFFSET, 32'h1, RESP_OKAY);
    wait_fetch(n);
    `CHK(seen_part & ~seen_full, 1'b1)
    rd(KEEP_OFFSET, keep, RESP_OKAY);
    rd(VDET_OFFSET, 32'h1, RESP_OKAY);
    rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
    rd(STAT_OFFSET, 32'h103, RESP_OKAY);
    $display("test software reset done");
    // watchdog then oscillator stop: first set not to reset (watchdog unselected, oscillator enabled with osc_act set), then set to reset
    for (int i = 0; i < 2; i++) begin
      wr(CTRL_OFFSET, (i == 1) ? 32'hc : 32'h0, RESP_OKAY);
      pulse(i);
      `CHK(rst_out.cpu_reset, 1'b0)
      wr(CTRL_OFFSET, (i == 1) ? 32'h4 : 32'h2, RESP_OKAY);
      seen_part = 1'b0;
      pulse(i);
      wait_fetch(n);
      `CHK(seen_part, 1'b1)
      rd(STAT_OFFSET, (i == 1) ? 32'h105 : 32'h104, RESP_OKAY);
      rd(VDET_OFFSET, 32'h1, RESP_OKAY);
      rd(KEEP_OFFSET, keep, RESP_OKAY);
    end
    $display("test watchdog and oscillator done");
    stop_mode <= 1'b1;
    u_supply.brownout(6);
    `CHK(rst_out.cpu_reset, 1'b0)
    stop_mode <= 1'b0;
    seen_full = 1'b0;
    u_supply.brownout(6);
    `CHK(rst_out.cpu_reset, 1'b1)
    wait_fetch(n);
    `CHK(seen_full, 1'b1)
    rd(STAT_OFFSET, 32'h102, RESP_OKAY);
    rd(VDET_OFFSET, 32'h0, RESP_OKAY);
    rd(KEEP_OFFSET, 32'h0, RESP_OKAY);
    u_supply.brownout(6);
    `CHK(rst_out.cpu_reset, 1'b0)
    $display("test brown-out done");
    wr(KEEP_OFFSET, keep, RESP_OKAY);
    u_supply.pin_reset(5);
    `CHK(rst_out.pins_reset && rst_out.osc_restart && rst_out.clk_sel_onchip, 1'b1)
    wait_fetch(n);
    `CHK(n inside {[10:13]}, 1'b1)
    rd(STAT_OFFSET, 32'h101, RESP_OKAY);
    rd(KEEP_OFFSET, 32'h0, RESP_OKAY);
    $display("test pin reset done");
    give_verdict();
  end
endmodule
